// [shared/ccr_pkg.sv]
// Package for the command/configuration register block.
// Assumes a 10 MHz host clock and an APB register port.
package ccr_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] CCR_OFF_CMD_CFG   = 8'h88;
	localparam logic [7:0] CCR_OFF_PM_ZERO   = 8'h90; // Mirror of PM reg zero
	localparam logic [7:0] CCR_OFF_CFG_ONE   = 8'h94; // Mirror of config reg one
	localparam logic [7:0] CCR_OFF_CAP_PTR   = 8'h98; // Capability pointer view
	localparam logic [7:0] CCR_OFF_STATUS    = 8'h9c; // Block status

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CCR_BIT_COLD_WAKE = 31;
	localparam int CCR_LSB_AUX_CUR   = 28;
	localparam int CCR_BIT_FOUR_LED  = 23;
	localparam int CCR_LSB_RX_FIFO   = 21;
	localparam int CCR_BIT_PM_EN     = 19;
	localparam int CCR_BIT_LAN_WAKE  = 18;
	localparam int CCR_BIT_PAT_RST   = 6;
	localparam int CCR_BIT_POWER_MGMT_REG_ZERO_WAKE = 31;
	localparam int CCR_BIT_CR1_NEWCAP = 20;

	// Writable bits of the command register; everything else except PM enable bit 19 reads 0
	localparam logic [31:0] CCR_WR_MASK  = 32'hf0e4_0040;
	localparam logic [15:0] CCR_LOAD_MASK = 16'hf0ec;

	// ----------------------------------------------------------------
	// Reset and coded values
	// ----------------------------------------------------------------
	localparam logic [2:0]  CCR_AUX_375MA   = 3'h7;
	localparam logic [2:0]  CCR_AUX_NONE    = 3'h0;
	localparam logic [1:0]  CCR_RFS_1K      = 2'h3;
	localparam logic [1:0]  CCR_RFS_2K      = 2'h2;
	localparam logic [1:0]  CCR_RFS_DEFAULT = 2'h2;
	localparam logic [7:0]  CCR_CAP_PTR_VAL = 8'h50; // Arbitrary pointer value
	localparam logic [11:0] CCR_FIFO_1K     = 12'h400;
	localparam logic [11:0] CCR_FIFO_2K     = 12'h800;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CCR_ST_LOAD,
		CCR_ST_RUN,
		CCR_ST_SLEEP
	} ccr_state_t;

	typedef struct packed {
		logic        valid;    // EEPROM word present
		logic [15:0] data;     // Bits 31..16 of the command register
	} ccr_load_t;

	typedef struct packed {
		logic magic;
		logic unicast;
		logic multicast;
	} ccr_frame_t;

	typedef struct packed {
		logic speed_or_link100;
		logic link_act_or_act;
		logic dup_col;
		logic act_only;
	} ccr_led_t;

	typedef struct packed {
		ccr_state_t  st;
		logic [31:0] cmd;
		logic        pm_wake;
		logic        aux_seen;
		logic [31:0] rdata;
		logic        slverr;
	} ccr_regs_t;

	function automatic logic [2:0] ccr_aux_default(input logic wake);
		return wake ? CCR_AUX_375MA : CCR_AUX_NONE;
	endfunction : ccr_aux_default

endpackage : ccr_pkg

// [sim/ccr_eeprom_model.sv]
// Serial configuration EEPROM loader model for the command register.
// Assumes srst is synchronous to clk; word is held stable by the bench.
`timescale 1ns/1ns
module ccr_eeprom_model
	import ccr_pkg::*;
(
	input  wire logic        clk,    // Host clock
	input  wire logic        srst,   // Sync reset, high
	input  wire logic [15:0] word,   // Stored upper half
	output ccr_load_t        load    // Word to the register
);
	logic sent_q;

	// Released bus shows the inverse so a stale value never looks valid
	always_ff @(posedge clk) begin
		if (srst) begin
			sent_q     <= 1'b0;
			load.valid <= 1'b0;
			load.data  <= ~word;
		end else begin
			load.valid <= !sent_q;
			load.data  <= sent_q ? ~word : word;
			sent_q     <= 1'b1;
		end
	end
endmodule : ccr_eeprom_model

// [sim/tb_command_power_config_register.sv]
// Self-checking bench for the command/configuration register.
// Assumes zero-wait APB slave and the EEPROM model on the load port.
`timescale 1ns/1ns
module tb_command_power_config_register
	import ccr_pkg::*;
;
	logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd;
	logic pready, pslverr, er, aux_power = 1'b1;
	logic link100 = 1'b0, link_up = 1'b0, activity = 1'b0, full_dup = 1'b0, collision = 1'b0;
	logic [31:0] prdata;
	logic [15:0] word = 16'hd0c8;
	ccr_frame_t frame_hit = '0;
	ccr_load_t ld;
	ccr_led_t led;
	logic led_four, pm_reg0_wake, cfg1_newcap, sleeping, wake_event, pat_ptr_rst;
	logic [11:0] rx_fifo_bytes;
	logic [7:0] cap_ptr;
	int n_fail = 0, num_checks = 0;

	always #50 clk = ~clk;

	ccr_eeprom_model u_rom (.clk(clk), .srst(srst), .word(word), .load(ld));

	ccr_command_config dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .eeprom_load(ld), .aux_power(aux_power),
		.frame_hit(frame_hit), .link100(link100), .link_up(link_up),
		.activity(activity), .full_dup(full_dup), .collision(collision), .led(led),
		.led_four(led_four), .rx_fifo_bytes(rx_fifo_bytes), .cap_ptr(cap_ptr),
		.pm_reg0_wake(pm_reg0_wake), .cfg1_newcap(cfg1_newcap), .sleeping(sleeping),
		.wake_event(wake_event), .pat_ptr_rst(pat_ptr_rst));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task wrap_up();
		if (n_fail == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20) begin
			n_fail++;
			wrap_up();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic do_reset(input logic [15:0] w);
		word <= w;
		srst <= 1'b1;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : do_reset

	task automatic pulse(input ccr_frame_t f, input logic ev, input logic sl);
		@(posedge clk);
		frame_hit <= f;
		#1;
		chk({31'h0, wake_event}, {31'h0, ev});
		@(posedge clk);
		frame_hit <= '0;
		#1;
		chk({31'h0, sleeping}, {31'h0, sl});
	endtask : pulse

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		do_reset(16'hd0c8);
		apb(1'b0, CCR_OFF_STATUS, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, CCR_OFF_CMD_CFG, 32'h0);
		chk(rd, 32'hf0c8_0000);
		chk({pm_reg0_wake, cfg1_newcap, cap_ptr}, {2'b11, CCR_CAP_PTR_VAL});
		link100 <= 1'b1;
		activity <= 1'b1;
		collision <= 1'b1;
		apb(1'b1, CCR_OFF_CMD_CFG, 32'hfff3_ffbf);
		apb(1'b0, CCR_OFF_CMD_CFG, 32'h0);
		chk(rd, 32'hf0e8_0000);
		chk({20'h0, rx_fifo_bytes}, 32'h400);
		chk({led_four, led.speed_or_link100, led.link_act_or_act, led.dup_col, led.act_only},
			5'h1e);
		apb(1'b1, CCR_OFF_CMD_CFG, 32'hf0c0_0040);
		#1;
		chk({31'h0, pat_ptr_rst}, 32'h1);
		@(posedge clk);
		#1;
		chk({31'h0, pat_ptr_rst}, 32'h0);
		chk({20'h0, rx_fifo_bytes}, 32'h800);
		apb(1'b1, CCR_OFF_CMD_CFG, 32'hf0c4_0000);
		@(posedge clk);
		#1;
		chk({31'h0, sleeping}, 32'h1);
		apb(1'b0, CCR_OFF_STATUS, 32'h0);
		chk(rd, 32'h2);
		pulse('{1'b0, 1'b1, 1'b0}, 1'b0, 1'b1);
		pulse('{1'b0, 1'b0, 1'b1}, 1'b0, 1'b1);
		pulse('{1'b1, 1'b0, 1'b0}, 1'b1, 1'b0);
		apb(1'b1, CCR_OFF_CMD_CFG, 32'hf0c4_0000);
		apb(1'b1, CCR_OFF_CMD_CFG, 32'hf0c0_0000);
		@(posedge clk);
		#1;
		chk({31'h0, sleeping}, 32'h0);
		pulse('{1'b0, 1'b1, 1'b0}, 1'b1, 1'b0);
		apb(1'b0, 8'ha0, 32'h0);
		chk({31'h0, er}, 32'h1);
		link100 <= 1'b0;
		activity <= 1'b0;
		collision <= 1'b0;
		full_dup <= 1'b1;
		do_reset(16'h0040);
		apb(1'b0, CCR_OFF_CMD_CFG, 32'h0);
		chk(rd, 32'h0040_0000);
		chk({31'h0, er}, 32'h0);
		chk({pm_reg0_wake, cfg1_newcap, cap_ptr}, 10'h0);
		chk({led_four, led.speed_or_link100, led.link_act_or_act, led.dup_col, led.act_only},
			5'h02);
		wrap_up();
	end
endmodule : tb_command_power_config_register

// [verilog/ccr_command_config.sv]
// Command/configuration register with EEPROM preload, LED mode, wake logic.
// Assumes an APB master on clk, an EEPROM loader that presents one word
// after reset, and PHY status inputs synchronous to clk.
//
// Function
// - Bits 31..28, 23..21, 19 and 18 loaded from EEPROM after reset
// - Cold wake cleared forces PM bit 31 low
// - Cold wake and aux power set PM bit31
// - Aux current loads 111b if cold wake and aux power, else the EEPROM value
// - LED mode 0: three combined indicators
// - LED mode 1: four indicators, duplex and collision still combined
// - FIFO size 11=1K, 10=2K, default 10
// - PM enable low gives zero capability pointer
// - PM enable mirrored into config bit 20
// - PM mode wakes on magic, unicast, multicast
// - Writing wake-on-LAN bit enters sleep at once
// - Sleep until wake event, clear or reset
// - Wake-on-LAN mode wakes on magic only
// - Bit 6 resets wake pattern pointer
`timescale 1ns/1ns
module ccr_command_config
	import ccr_pkg::*;
(
	input  wire logic        clk,         // 10 MHz clock
	input  wire logic        srst,        // Sync reset, high
	input  wire logic        psel,        // APB select
	input  wire logic        penable,     // APB enable
	input  wire logic        pwrite,      // APB direction
	input  wire logic [7:0]  paddr,       // APB byte address
	input  wire logic [31:0] pwdata,      // APB write data
	output logic             pready,      // APB ready
	output logic [31:0]      prdata,      // APB read data
	output logic             pslverr,     // APB error
	input  wire ccr_load_t   eeprom_load, // EEPROM word for bits 31..16
	input  wire logic        aux_power,   // Aux supply sensed
	input  wire ccr_frame_t  frame_hit,   // Frame matcher pulses
	input  wire logic        link100,     // PHY 100M link
	input  wire logic        link_up,     // PHY link
	input  wire logic        activity,    // PHY activity
	input  wire logic        full_dup,    // PHY full duplex
	input  wire logic        collision,   // PHY collision
	output ccr_led_t         led,         // Indicator drive
	output logic             led_four,    // Four indicators in use
	output logic [11:0]      rx_fifo_bytes, // Selected receive FIFO size
	output logic [7:0]       cap_ptr,     // Capability pointer
	output logic             pm_reg0_wake, // PM reg zero bit 31
	output logic             cfg1_newcap, // Config reg one bit 20
	output logic             sleeping,    // Sleep state
	output logic             wake_event,  // Wake-up pulse
	output logic             pat_ptr_rst  // Wake pattern pointer reset
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	ccr_regs_t q;
	ccr_regs_t d;
	logic      wr_acc;
	logic      rd_acc;
	logic      hit_addr;
	logic      wake_ok;
	logic [31:0] wmerge;

	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && penable && !pwrite;
	assign hit_addr = (paddr == CCR_OFF_CMD_CFG) || (paddr == CCR_OFF_PM_ZERO) ||
		(paddr == CCR_OFF_CFG_ONE) || (paddr == CCR_OFF_CAP_PTR) ||
		(paddr == CCR_OFF_STATUS);

	// Wake frame class depends on mode
	always_comb begin
		if (q.cmd[CCR_BIT_LAN_WAKE])
			wake_ok = frame_hit.magic;
		else
			wake_ok = q.cmd[CCR_BIT_PM_EN] &&
				(frame_hit.magic || frame_hit.unicast || frame_hit.multicast);
	end

	// Read-only PM enable bit is kept from load; software cannot touch it
	always_comb begin
		wmerge = (q.cmd & ~CCR_WR_MASK) | (pwdata & CCR_WR_MASK);
		wmerge[CCR_BIT_PM_EN] = q.cmd[CCR_BIT_PM_EN];
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		d.rdata = 32'h0000_0000;
		d.slverr = 1'b0;
		d.aux_seen = aux_power;
		case (q.st)
			CCR_ST_LOAD: begin
				if (eeprom_load.valid) begin
					d.cmd[31:16] = eeprom_load.data & CCR_LOAD_MASK;
					if (eeprom_load.data[CCR_BIT_COLD_WAKE-16] && aux_power)
						d.cmd[30:28] = ccr_aux_default(1'b1);
					d.st = CCR_ST_RUN;
				end
			end
			CCR_ST_RUN: begin
				if (wr_acc && paddr == CCR_OFF_CMD_CFG) begin
					d.cmd = wmerge;
					if (pwdata[CCR_BIT_LAN_WAKE])
						d.st = CCR_ST_SLEEP;
				end
			end
			CCR_ST_SLEEP: begin
				if (wake_ok) begin
					d.st = CCR_ST_RUN;
				end
				if (wr_acc && paddr == CCR_OFF_CMD_CFG) begin
					d.cmd = wmerge;
					if (!pwdata[CCR_BIT_LAN_WAKE])
						d.st = CCR_ST_RUN;
				end
			end
			default: d.st = CCR_ST_LOAD;
		endcase
		// Pattern reset is a command: self clears after one cycle
		if (q.cmd[CCR_BIT_PAT_RST] && !(wr_acc && paddr == CCR_OFF_CMD_CFG))
			d.cmd[CCR_BIT_PAT_RST] = 1'b0;
		d.pm_wake = d.cmd[CCR_BIT_COLD_WAKE] && aux_power;
		if (rd_acc) begin
			case (paddr)
				CCR_OFF_CMD_CFG: d.rdata = q.cmd & CCR_WR_MASK |
					(32'h0000_0001 << CCR_BIT_PM_EN) & q.cmd;
				CCR_OFF_PM_ZERO: d.rdata = {q.pm_wake, 31'h0000_0000};
				CCR_OFF_CFG_ONE: d.rdata = {11'h000, q.cmd[CCR_BIT_PM_EN], 20'h0_0000};
				CCR_OFF_CAP_PTR: d.rdata = {24'h00_0000, cap_ptr};
				CCR_OFF_STATUS:  d.rdata = {30'h0000_0000, q.st};
				default:         d.slverr = 1'b1;
			endcase
		end
		if (wr_acc && !hit_addr)
			d.slverr = 1'b1;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			q.st       <= CCR_ST_LOAD;
			q.cmd      <= {CCR_AUX_NONE, 1'b0, 5'h00, CCR_RFS_DEFAULT, 21'h00_0000} |
				32'h0000_0000;
			q.pm_wake  <= 1'b0;
			q.aux_seen <= 1'b0;
			q.rdata    <= 32'h0000_0000;
			q.slverr   <= 1'b0;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Data phase answers in the access cycle; read data combinational
	assign pready  = 1'b1;
	always_comb begin
		prdata  = 32'h0000_0000;
		pslverr = 1'b0;
		if (rd_acc && hit_addr) begin
			case (paddr)
				CCR_OFF_CMD_CFG: prdata = q.cmd & (CCR_WR_MASK | 32'h0008_0000);
				CCR_OFF_PM_ZERO: prdata = {q.pm_wake, 31'h0000_0000};
				CCR_OFF_CFG_ONE: prdata = {11'h000, cfg1_newcap, 20'h0_0000};
				CCR_OFF_CAP_PTR: prdata = {24'h00_0000, cap_ptr};
				default:         prdata = {30'h0000_0000, q.st};
			endcase
		end
		if (psel && penable && !hit_addr)
			pslverr = 1'b1;
	end

	assign pm_reg0_wake = q.pm_wake;
	assign cfg1_newcap  = q.cmd[CCR_BIT_PM_EN];
	assign cap_ptr      = q.cmd[CCR_BIT_PM_EN] ? CCR_CAP_PTR_VAL : 8'h00;
	assign sleeping     = (q.st == CCR_ST_SLEEP);
	// Awake in PM mode the wake frames are still reported to the host
	assign wake_event   = (q.st != CCR_ST_LOAD) && wake_ok;
	assign pat_ptr_rst  = q.cmd[CCR_BIT_PAT_RST];
	assign led_four     = q.cmd[CCR_BIT_FOUR_LED];
	// Reserved codes fall back to the larger size
	assign rx_fifo_bytes = (q.cmd[22:21] == CCR_RFS_1K) ? CCR_FIFO_1K : CCR_FIFO_2K;

	always_comb begin
		if (q.cmd[CCR_BIT_FOUR_LED]) begin
			led.speed_or_link100 = link100;
			led.link_act_or_act  = activity;
			led.dup_col          = full_dup || collision;
			led.act_only         = link_up;
		end else begin
			led.speed_or_link100 = link100;
			led.link_act_or_act  = link_up || activity;
			led.dup_col          = full_dup || collision;
			led.act_only         = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_load;
		@(posedge clk) disable iff (srst)
		(q.st == CCR_ST_LOAD && eeprom_load.valid) |=>
			(q.cmd[31:16] & 16'h8fff) == ($past(eeprom_load.data) & CCR_LOAD_MASK & 16'h8fff);
	endproperty
	a_load: assert property (p_load) else $error("EEPROM load wrong");

	property p_cold_off;
		@(posedge clk) disable iff (srst)
		!q.cmd[CCR_BIT_COLD_WAKE] |-> !pm_reg0_wake;
	endproperty
	a_cold_off: assert property (p_cold_off) else $error("PM wake not cleared");

	property p_cold_on;
		@(posedge clk) disable iff (srst)
		(d.cmd[CCR_BIT_COLD_WAKE] && aux_power) |=> pm_reg0_wake;
	endproperty
	a_cold_on: assert property (p_cold_on) else $error("PM wake not set");

	property p_cap;
		@(posedge clk) disable iff (srst)
		!q.cmd[CCR_BIT_PM_EN] |-> cap_ptr == 8'h00 && !cfg1_newcap;
	endproperty
	a_cap: assert property (p_cap) else $error("Capability pointer not zero");

	property p_sleep;
		@(posedge clk) disable iff (srst)
		(q.st == CCR_ST_RUN && wr_acc && paddr == CCR_OFF_CMD_CFG &&
			pwdata[CCR_BIT_LAN_WAKE]) |=> sleeping;
	endproperty
	a_sleep: assert property (p_sleep) else $error("Sleep not entered");

	sequence s_asleep_quiet;
		sleeping && !wake_ok && !(wr_acc && paddr == CCR_OFF_CMD_CFG);
	endsequence
	property p_stay;
		@(posedge clk) disable iff (srst)
		s_asleep_quiet |=> sleeping;
	endproperty
	a_stay: assert property (p_stay) else $error("Left sleep early");

	property p_magic_only;
		@(posedge clk) disable iff (srst)
		(sleeping && q.cmd[CCR_BIT_LAN_WAKE] && !frame_hit.magic) |-> !wake_event;
	endproperty
	a_magic_only: assert property (p_magic_only) else $error("Non-magic wake");

	property p_pat;
		@(posedge clk) disable iff (srst)
		pat_ptr_rst && !(wr_acc && paddr == CCR_OFF_CMD_CFG) |=> !pat_ptr_rst;
	endproperty
	a_pat: assert property (p_pat) else $error("Pattern reset stuck");

	property p_rsvd;
		@(posedge clk) disable iff (srst)
		(q.cmd & ~(CCR_WR_MASK | 32'h0008_0000)) == 32'h0000_0000;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("Reserved bit set");

	property p_rsvd_read;
		@(posedge clk) disable iff (srst)
		(rd_acc && paddr == CCR_OFF_CMD_CFG) |->
			(prdata & ~(CCR_WR_MASK | 32'h0008_0000)) == 32'h0000_0000;
	endproperty
	a_rsvd_read: assert property (p_rsvd_read) else $error("Reserved bit read");

	property p_aux_load;
		@(posedge clk) disable iff (srst)
		(q.st == CCR_ST_LOAD && eeprom_load.valid &&
			eeprom_load.data[CCR_BIT_COLD_WAKE-16] && aux_power) |=>
			q.cmd[30:28] == CCR_AUX_375MA;
	endproperty
	a_aux_load: assert property (p_aux_load) else $error("Aux load not 111b");

	property p_aux_kept;
		@(posedge clk) disable iff (srst)
		(q.st == CCR_ST_LOAD && eeprom_load.valid &&
			!(eeprom_load.data[CCR_BIT_COLD_WAKE-16] && aux_power)) |=>
			q.cmd[30:28] == $past(eeprom_load.data[14:12]);
	endproperty
	a_aux_kept: assert property (p_aux_kept) else $error("Aux load altered");

	property p_led_three;
		@(posedge clk) disable iff (srst)
		!led_four |-> led.speed_or_link100 == link100 &&
			led.link_act_or_act == (link_up || activity) &&
			led.dup_col == (full_dup || collision) && !led.act_only;
	endproperty
	a_led_three: assert property (p_led_three) else $error("Three LED mode wrong");

	property p_led_four;
		@(posedge clk) disable iff (srst)
		led_four |-> led.speed_or_link100 == link100 &&
			led.link_act_or_act == activity && led.act_only == link_up &&
			led.dup_col == (full_dup || collision);
	endproperty
	a_led_four: assert property (p_led_four) else $error("Four LED mode wrong");

	property p_fifo_small;
		@(posedge clk) disable iff (srst)
		q.cmd[22:21] == CCR_RFS_1K |-> rx_fifo_bytes == CCR_FIFO_1K;
	endproperty
	a_fifo_small: assert property (p_fifo_small) else $error("FIFO not 1K");

	property p_fifo_large;
		@(posedge clk) disable iff (srst)
		q.cmd[22:21] != CCR_RFS_1K |-> rx_fifo_bytes == CCR_FIFO_2K;
	endproperty
	a_fifo_large: assert property (p_fifo_large) else $error("FIFO not 2K");

	property p_newcap_read;
		@(posedge clk) disable iff (srst)
		(rd_acc && paddr == CCR_OFF_CFG_ONE) |->
			prdata[CCR_BIT_CR1_NEWCAP] == q.cmd[CCR_BIT_PM_EN];
	endproperty
	a_newcap_read: assert property (p_newcap_read) else $error("New cap bit wrong");

	sequence s_pm_frame;
		q.st == CCR_ST_RUN && !q.cmd[CCR_BIT_LAN_WAKE] && q.cmd[CCR_BIT_PM_EN] &&
			(frame_hit.magic || frame_hit.unicast || frame_hit.multicast);
	endsequence
	property p_pm_frame;
		@(posedge clk) disable iff (srst)
		s_pm_frame |-> wake_event;
	endproperty
	a_pm_frame: assert property (p_pm_frame) else $error("PM wake frame lost");

	property p_wake_exit;
		@(posedge clk) disable iff (srst)
		(sleeping && wake_ok) |=> !sleeping;
	endproperty
	a_wake_exit: assert property (p_wake_exit) else $error("Sleep not left");

endmodule : ccr_command_config
